/* core/lbd_defines.svh */
// constants of the latched bus driver: widths, depths, reset values
`ifndef LBD_DEFINES_SVH
`define LBD_DEFINES_SVH

// data bits carried from input word to output word
`define LBD_DATA_W 18
// words of buffering between the storage element and the output pins
`define LBD_FIFO_DEPTH 8
// stored word and output word after reset
`define LBD_STORE_RST 18'h0_0000
// pad output enable after reset: high means released, not driving
`define LBD_OE_N_RST 1'b1
// synchroniser depth for pin inputs
`define LBD_SYNC_STAGES 2

`endif

/* core/lbd_driver.sv */
// 18-bit latched bus driver: transparent, edge capture, hold, tristate
`timescale 1ns/100ps
`include "lbd_defines.svh"

// Behaviour
// - eighteen bits share one gate, clock, enable
// - gate high: stored word follows input
// - gate low: capture input on clock rise
// - gate low, clock steady: hold stored word
// - drive_n high: all 18 data outputs released; path_ready keeps driving
// - drive_n low: outputs drive the stored path
module lbd_driver #(
   parameter int WIDTH = `LBD_DATA_W,
   parameter int DEPTH = `LBD_FIFO_DEPTH
) (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic [WIDTH-1:0] data_in,
   input wire logic transparent_gate,
   input wire logic capture_clk,
   input wire logic output_drive_n,
   output logic [WIDTH-1:0] data_out,
   output logic data_oe_n,
   output logic path_ready
);

   ////////////////////////////////////////////////////////////////////
   // the word type fixes the width; other widths are refused
   generate
      if (WIDTH != $bits(lbd_pkg::lbd_word_t))
      begin : g_bad_width
         $error("lbd_driver: WIDTH must match the data word");
      end
   endgenerate

   // synchroniser stages; stage one is read only by stage two
   logic [WIDTH-1:0] data_m_r;
   logic [WIDTH-1:0] data_s_r;
   lbd_pkg::lbd_ctrl_s ctrl_m_r;
   lbd_pkg::lbd_ctrl_s ctrl_s_r;
   logic cap_old_r;              // previous synced clock level
   logic cap_rise;               // one-cycle capture event

   // storage element and its next value
   lbd_pkg::lbd_word_t store_r;
   lbd_pkg::lbd_word_t store_nxt;
   logic store_load;             // word offered to the buffer this cycle

   // output side
   logic [WIDTH-1:0] data_out_r;
   logic data_oe_n_r;
   logic path_ready_r;

   // fifo hookup
   logic fifo_in_ready;
   logic [WIDTH-1:0] fifo_out_data;
   logic fifo_out_valid;
   logic drain_ready;

   ////////////////////////////////////////////////////////////////////
   // pins arrive asynchronously; bits of a word are synced side by
   // side, so a word changing near a sample may be seen torn for one
   // cycle; the next cycle settles it
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         data_m_r <= `LBD_STORE_RST;
         data_s_r <= `LBD_STORE_RST;
         ctrl_m_r <= {1'b0, 1'b0, `LBD_OE_N_RST};
         ctrl_s_r <= {1'b0, 1'b0, `LBD_OE_N_RST};
      end
      else
      begin
         data_m_r <= data_in;
         data_s_r <= data_m_r;
         ctrl_m_r <= {transparent_gate, capture_clk, output_drive_n};
         ctrl_s_r <= ctrl_m_r;
      end
   end

   // edge detector works on the second stage only
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         cap_old_r <= 1'b0;
      end
      else
      begin
         cap_old_r <= ctrl_s_r.cap_clk;
      end
   end

   assign cap_rise = ctrl_s_r.cap_clk && !cap_old_r;

   ////////////////////////////////////////////////////////////////////
   // storage element; the enable plays no part here
   always_comb
   begin
      store_nxt = store_r;
      store_load = 1'b0;
      if (ctrl_s_r.gate)
      begin
         // transparent: follow, counting only real changes
         store_nxt = data_s_r;
         store_load = (data_s_r != store_r);
      end
      else if (cap_rise)
      begin
         // edge capture, even when the value is unchanged
         store_nxt = data_s_r;
         store_load = 1'b1;
      end
      else
      begin
         store_nxt = store_r;
      end
   end

   // stored word register, shared by all bits
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         store_r <= `LBD_STORE_RST;
      end
      else
      begin
         store_r <= store_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // buffer between storage and pins; it drains only while driving,
   // so a released bus lets words pile up until the buffer refuses further words
   assign drain_ready = !ctrl_s_r.drive_n;

   lbd_fifo #(
      .WIDTH(WIDTH),
      .DEPTH(DEPTH)
   ) u_fifo (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .in_data(store_nxt),
      .in_valid(store_load),
      .in_ready(fifo_in_ready),
      .out_data(fifo_out_data),
      .out_valid(fifo_out_valid),
      .out_ready(drain_ready)
   );

   // output word, updated only from the buffer while driving
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         data_out_r <= `LBD_STORE_RST;
      end
      else if (fifo_out_valid && drain_ready)
      begin
         data_out_r <= fifo_out_data;
      end
   end

   // pad enable follows the synced enable; word stays untouched
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         data_oe_n_r <= `LBD_OE_N_RST;
         path_ready_r <= 1'b0;
      end
      else
      begin
         data_oe_n_r <= ctrl_s_r.drive_n;
         path_ready_r <= fifo_in_ready;
      end
   end

   assign data_out = data_out_r;
   assign data_oe_n = data_oe_n_r;
   assign path_ready = path_ready_r;

   ////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   sequence s_capture;
      !ctrl_s_r.gate && cap_rise;
   endsequence

   sequence s_steady;
      !ctrl_s_r.gate && !cap_rise;
   endsequence

   property p_lanes;
      fifo_out_valid && drain_ready |=>
         data_out_r == $past(fifo_out_data);
   endproperty
   a_lanes: assert property (p_lanes)
      else $error("output word not taken from buffer");

   property p_follow;
      ctrl_s_r.gate |=> store_r == $past(data_s_r);
   endproperty
   a_follow: assert property (p_follow)
      else $error("transparent word not followed");

   property p_capture;
      s_capture |=> store_r == $past(data_s_r);
   endproperty
   a_capture: assert property (p_capture)
      else $error("edge capture missed");

   property p_hold;
      s_steady |=> $stable(store_r);
   endproperty
   a_hold: assert property (p_hold)
      else $error("held word changed");

   property p_release;
      ctrl_s_r.drive_n ##1 ctrl_s_r.drive_n |=>
         data_oe_n_r && $stable(data_out_r);
   endproperty
   a_release: assert property (p_release)
      else $error("output not released");

   property p_drive;
      !ctrl_s_r.drive_n |=> !data_oe_n_r;
   endproperty
   a_drive: assert property (p_drive)
      else $error("output not driven");

   property p_enable_neutral;
      $changed(ctrl_s_r.drive_n) and s_steady |=> $stable(store_r);
   endproperty
   a_enable_neutral: assert property (p_enable_neutral)
      else $error("enable toggle disturbed stored word");

   property p_capture_queued;
      (s_capture and fifo_in_ready) ##1 !ctrl_s_r.drive_n [*3]
         |-> fifo_out_valid || data_out_r == store_r;
   endproperty
   a_capture_queued: assert property (p_capture_queued)
      else $error("captured word lost on the way out");

endmodule

/* core/lbd_fifo.sv */
// small first-word-fall-through fifo with valid/ready on both sides
`timescale 1ns/100ps
`include "lbd_defines.svh"

module lbd_fifo #(
   parameter int WIDTH = `LBD_DATA_W,
   parameter int DEPTH = `LBD_FIFO_DEPTH
) (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);

   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   ////////////////////////////////////////////////////////////////////
   // pointer arithmetic wraps, so only powers of two are served
   generate
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
      begin : g_bad_param
         $error("lbd_fifo: DEPTH must be a power of two >= 2");
      end
   endgenerate

   logic [WIDTH-1:0] mem_r [DEPTH];  // word storage, no reset needed
   logic [AW-1:0] wr_ptr_r;          // next slot to fill
   logic [AW-1:0] rd_ptr_r;          // oldest slot
   logic [AW:0] count_r;             // words held, one bit wider
   logic push;
   logic pop;

   ////////////////////////////////////////////////////////////////////
   // honest flags straight from the count
   assign in_ready = (count_r != DEPTH[AW:0]);
   assign out_valid = (count_r != '0);
   assign out_data = mem_r[rd_ptr_r];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // storage write, only on an accepted word
   always_ff @(posedge ref_clk)
   begin
      if (push)
      begin
         mem_r[wr_ptr_r] <= in_data;
      end
   end

   // pointers and fill count
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (pop)
         begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
         end
         // simultaneous push and pop leave the count alone
         if (push && !pop)
         begin
            count_r <= count_r + 1'b1;
         end
         else if (pop && !push)
         begin
            count_r <= count_r - 1'b1;
         end
      end
   end

endmodule

/* core/lbd_pkg.sv */
// types shared by the latched bus driver files
`include "lbd_defines.svh"

package lbd_pkg;

   // one data word as it travels from pins to pins
   typedef logic [`LBD_DATA_W-1:0] lbd_word_t;

   // control pins travelling together after synchronisation
   typedef struct packed
   {
      logic gate;     // transparent_gate level
      logic cap_clk;  // capture clock level
      logic drive_n;  // output_drive_n level
   } lbd_ctrl_s;

endpackage

/* dv/latched_bus_driver_18bit_bench.sv */
// self-checking bench of the latched bus driver
`timescale 1ns/100ps

module latched_bus_driver_18bit_bench;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic [17:0] data_in = 18'h0_0000;
   logic transparent_gate = 1'b0;
   logic capture_clk = 1'b0;
   logic output_drive_n = 1'b1;
   logic [17:0] data_out;
   logic data_oe_n;
   logic path_ready;
   logic [17:0] bus_level;
   int errors = 0;
   int check_count = 0;
   int cycles = 0;

   ////////////////////////////////////////////////////////////////////
   initial
   begin
      forever #25 ref_clk = ~ref_clk;
   end

   lbd_driver i_lbd_driver (
      .ref_clk(ref_clk), .nrst(nrst), .data_in(data_in),
      .transparent_gate(transparent_gate), .capture_clk(capture_clk),
      .output_drive_n(output_drive_n), .data_out(data_out),
      .data_oe_n(data_oe_n), .path_ready(path_ready)
   );

   lbd_bus_load i_lbd_bus_load (
      .ref_clk(ref_clk), .data_out(data_out),
      .data_oe_n(data_oe_n), .bus_level(bus_level)
   );

   ////////////////////////////////////////////////////////////////////
   // compare and count
   task automatic check(input string what, input logic [17:0] seen,
      input logic [17:0] exp);
   begin
      check_count++;
      if (seen !== exp)
      begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   end
   endtask

   task automatic cyc(input int n);
   begin
      repeat (n) @(negedge ref_clk);
   end
   endtask

   // one capture edge, slow enough for the synchroniser
   task automatic cap(input logic [17:0] v);
   begin
      data_in = v;
      cyc(3);
      capture_clk = 1'b1;
      cyc(3);
      capture_clk = 1'b0;
      cyc(3);
   end
   endtask

   task automatic tally_and_finish;
   begin
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   end
   endtask

   // hang guard: whole run needs a few hundred cycles
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         errors++;
         tally_and_finish();
      end
   end

   ////////////////////////////////////////////////////////////////////
   // gate high: output follows input, all 18 bits
   task automatic t_transparent;
   begin
      output_drive_n = 1'b0;
      transparent_gate = 1'b1;
      data_in = 18'h2_5A5A;
      cyc(8);
      check("transp", data_out, 18'h2_5A5A);
      check("bus", bus_level, 18'h2_5A5A);
      data_in = 18'h1_A5A5;
      cyc(8);
      check("follow", data_out, 18'h1_A5A5);
      transparent_gate = 1'b0;
      cyc(4);
   end
   endtask

   // gate low: capture on rise, hold while clock steady
   task automatic t_capture;
   begin
      cap(18'h3_0F0F);
      cyc(3);
      check("capture", data_out, 18'h3_0F0F);
      data_in = 18'h0_FFFF;
      cyc(10);
      check("hold", data_out, 18'h3_0F0F);
      // the rise itself captures, so it must see the held word again
      data_in = 18'h3_0F0F;
      cyc(3);
      capture_clk = 1'b1;
      cyc(3);
      data_in = 18'h0_FFFF;
      cyc(10);
      check("hold_hi", data_out, 18'h3_0F0F);
      capture_clk = 1'b0;
      cyc(4);
      check("hold_fall", data_out, 18'h3_0F0F);
   end
   endtask

   // reset in mid-run clears the path, then drive comes back
   task automatic t_reset;
   begin
      nrst = 1'b0;
      cyc(4);
      check("rr_out", data_out, 18'h0_0000);
      check("rr_oe", {17'h0_0000, data_oe_n}, 18'h0_0001);
      check("rr_rdy", {17'h0_0000, path_ready}, 18'h0_0000);
      nrst = 1'b1;
      cyc(4);
      check("rr_room", {17'h0_0000, path_ready}, 18'h0_0001);
      check("rr_drive", {17'h0_0000, data_oe_n}, 18'h0_0000);
      check("rr_keep", data_out, 18'h0_0000);
   end
   endtask

   // released outputs; toggling enable keeps the stored word
   task automatic t_release;
   begin
      output_drive_n = 1'b1;
      cyc(5);
      check("oe_off", {17'h0_0000, data_oe_n}, 18'h0_0001);
      check("bus_z", bus_level, ~18'h3_0F0F);
      output_drive_n = 1'b0;
      cyc(5);
      check("oe_on", {17'h0_0000, data_oe_n}, 18'h0_0000);
      check("kept", data_out, 18'h3_0F0F);
   end
   endtask

   // buffer fills while released, refuses the ninth, drains to the eighth word
   task automatic t_fill;
   begin
      output_drive_n = 1'b1;
      cyc(5);
      for (int i = 0; i < 9; i++)
         cap(18'h0_0010 + 18'(i));
      check("full", {17'h0_0000, path_ready}, 18'h0_0000);
      output_drive_n = 1'b0;
      cyc(20);
      check("room", {17'h0_0000, path_ready}, 18'h0_0001);
      check("last", data_out, 18'h0_0017);
   end
   endtask

   ////////////////////////////////////////////////////////////////////
   initial
   begin
      cyc(16);
      check("rst_out", data_out, 18'h0_0000);
      check("rst_oe", {17'h0_0000, data_oe_n}, 18'h0_0001);
      nrst = 1'b1;
      cyc(4);
      t_transparent();
      t_capture();
      t_release();
      t_fill();
      t_reset();
      tally_and_finish();
   end
endmodule

/* dv/lbd_bus_load.sv */
// far-side load model: the module lines fed by the driver
`timescale 1ns/100ps

module lbd_bus_load (
   input wire logic ref_clk,
   input wire logic [17:0] data_out,
   input wire logic data_oe_n,
   output logic [17:0] bus_level
);
   logic [17:0] last_r; // last value actually driven

   ////////////////////////////////////////////////////////////////////
   // remember the driven word, so a released bus can show its inverse
   always_ff @(posedge ref_clk)
   begin
      if (data_oe_n == 1'b0)
         last_r <= data_out;
   end

   // no keeper on these lines: released shows inverse, not a stale copy
   assign bus_level = (data_oe_n == 1'b0) ? data_out : ~last_r;
endmodule
